//--- brownout_reset_pkg.sv
// Constants, layouts and types shared by the reset sequencing logic
package brownout_reset_pkg;

   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned PUD_TIME_MS     = 64;
   localparam int unsigned PUD_CYC         = PUD_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned DEGLITCH_TIME_US = 2;
   localparam int unsigned DEGLITCH_CYC    =
      (DEGLITCH_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
      DEGLITCH_TIME_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned CNT_W           = 20;

   // -------------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [1:0] IDX_CTRL_STATUS = 2'h0;  // offset 0x00
   localparam logic [1:0] IDX_CONFIG      = 2'h1;  // offset 0x04
   localparam logic [1:0] IDX_INT_STATUS  = 2'h2;  // offset 0x08
   localparam logic [1:0] IDX_INT_MASK    = 2'h3;  // offset 0x0C

   // Control/status fields
   localparam int unsigned CSR_SW_EN_BIT  = 7;
   localparam int unsigned CSR_READY_BIT  = 0;
   localparam logic        SW_EN_RESET    = 1'b1;

   // Configuration fields
   localparam int unsigned CFG_MODE_LSB   = 0;
   localparam int unsigned CFG_PUD_N_BIT  = 2;
   localparam logic [1:0]  MODE_RESET     = 2'h3;
   localparam logic        PUD_N_RESET    = 1'b0;

   // Interrupt fields
   localparam int unsigned INT_W          = 3;
   localparam int unsigned INT_BOR_BIT    = 0;
   localparam int unsigned INT_PUD_BIT    = 1;
   localparam int unsigned INT_READY_BIT  = 2;
   localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

   // Brown-out mode encodings
   localparam logic [1:0] MODE_ALWAYS_ON   = 2'h3;
   localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
   localparam logic [1:0] MODE_SW_CTRL     = 2'h1;
   localparam logic [1:0] MODE_ALWAYS_OFF  = 2'h0;

   // Synchroniser lanes
   localparam int unsigned SY_W   = 4;
   localparam int unsigned SY_POR = 0;
   localparam int unsigned SY_LOW = 1;
   localparam int unsigned SY_RDY = 2;
   localparam int unsigned SY_PIN = 3;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {PH_HOLD, PH_WAIT_BOR, PH_DELAY, PH_RUN}
      phase_type;

   typedef struct packed {
      logic [SY_W-1:0]  sync1;
      logic [SY_W-1:0]  sync2;
      phase_type        phase;
      logic [CNT_W-1:0] pud_cnt;
      logic [CNT_W-1:0] dg_cnt;
      logic             sw_en;
      logic [1:0]       mode;
      logic             pud_n;
      logic [INT_W-1:0] int_status;
      logic [INT_W-1:0] int_mask;
      logic             rdy_prev;
      logic             pulse_rst;
      logic             rstn;
      logic             dp_wr;
      logic             dp_ok;
      logic [1:0]       dp_idx;
      logic [31:0]      hrdata;
   } state_type;

endpackage

//--- brownout_powerup_reset_ctrl.sv
// Reset merging, power-up delay and brown-out control with AHB-Lite access
//
// What this block does
// - Reset on power-on, brown-out, pin, watchdog, instruction, stack, prog exit.
// - Power-up delay of nominally 64 ms after power-on or brown-out.
// - Internal reset stays asserted while the power-up delay counts.
// - Delay runs only when its active-low enable is clear; else bypassed.
// - Delay starts only after power-on and brown-out conditions both release.
// - Reset held while the power-on detector reports low supply.
// - Mode 11 always on, 10 off in sleep, 01 software, 00 off.
// - Brown-out reset only after low supply outlasts the deglitch time.
// - Modes 11 and 10 delay start-up until ready and above threshold.
// - Mode 11 keeps protection in sleep and does not delay wake-up.
// - Mode 10 drops protection in sleep; wake-up waits for ready.
// - Mode 01 follows software enable; start-up never waits for detector.
// - Software mode protects once ready; sleep does not change it.
// - Software enable bit 7 always read/write, set by power-on/brown-out.
// - Bit 0 reads detector enabled and ready; bits 6 to 1 read zero.
`timescale 1ns/1ns
`default_nettype none

module brownout_powerup_reset_ctrl #(
   parameter int unsigned POWERUP_DELAY_CYCLES = brownout_reset_pkg::PUD_CYC,
   parameter int unsigned DEGLITCH_CYCLES = brownout_reset_pkg::DEGLITCH_CYC
) (
   input  wire logic        i_ref_clk,         // Device clock, 10 MHz
   input  wire logic        i_resetn,          // Async power-on reset
   input  wire logic        i_por_low,         // Power-on detector, low
   input  wire logic        i_below_threshold, // Supply under brown-out level
   input  wire logic        i_bor_circuit_rdy, // Detector reports ready
   input  wire logic        i_ext_reset_n,     // External reset pin
   input  wire logic        i_wdt_reset,       // Watchdog reset pulse
   input  wire logic        i_reset_instr,     // Reset instruction pulse
   input  wire logic        i_stack_overflow,  // Stack overflow pulse
   input  wire logic        i_stack_underflow, // Stack underflow pulse
   input  wire logic        i_prog_exit,       // Programming mode exit pulse
   input  wire logic        i_sleep,           // Core is in sleep
   input  wire logic        i_hsel,            // AHB select
   input  wire logic [31:0] i_haddr,           // AHB address
   input  wire logic [1:0]  i_htrans,          // AHB transfer type
   input  wire logic        i_hwrite,          // AHB write
   input  wire logic [2:0]  i_hsize,           // AHB size, word only
   input  wire logic        i_hready,          // AHB bus ready
   input  wire logic [31:0] i_hwdata,          // AHB write data
   output logic [31:0]      o_hrdata,          // AHB read data
   output logic             o_hreadyout,       // AHB slave ready
   output logic             o_hresp,           // AHB response, OKAY
   output logic             o_device_reset_n,  // Merged device reset
   output logic             o_brownout_enable, // Enables the detector
   output logic             o_wake_ready,      // Wake-up may proceed
   output logic             o_irq              // Level interrupt
);

   // -------------------------------------------------------------------
   // State and derived levels
   // -------------------------------------------------------------------
   brownout_reset_pkg::state_type st_reg;
   brownout_reset_pkg::state_type st_next;

   logic                                  por_low;
   logic                                  below;
   logic                                  pin_low;
   logic                                  bor_active;
   logic                                  rdy;
   logic                                  bor_cond;
   logic                                  bor_event;
   logic                                  pud_done;
   logic                                  take;
   logic                                  mapped;
   logic [brownout_reset_pkg::INT_W-1:0]  int_set;
   logic [brownout_reset_pkg::INT_W-1:0]  int_clr;

   localparam logic [brownout_reset_pkg::CNT_W-1:0] PUD_LAST =
      brownout_reset_pkg::CNT_W'(POWERUP_DELAY_CYCLES - 1);
   localparam logic [brownout_reset_pkg::CNT_W-1:0] DG_LAST =
      brownout_reset_pkg::CNT_W'(DEGLITCH_CYCLES - 1);

   // Detector on/off by mode, software bit and sleep
   function automatic logic detector_on(input logic [1:0] mode,
                                        input logic       sw_en,
                                        input logic       sleep);
      logic on;
      on = 1'b0;
      unique case (mode)
         brownout_reset_pkg::MODE_ALWAYS_ON:    on = 1'b1;
         brownout_reset_pkg::MODE_OFF_IN_SLEEP: on = !sleep;
         brownout_reset_pkg::MODE_SW_CTRL:      on = sw_en;
         brownout_reset_pkg::MODE_ALWAYS_OFF:   on = 1'b0;
      endcase
      return on;
   endfunction

   // Modes whose start-up waits for the detector
   function automatic logic waits_for_detector(input logic [1:0] mode);
      return (mode == brownout_reset_pkg::MODE_ALWAYS_ON) ||
             (mode == brownout_reset_pkg::MODE_OFF_IN_SLEEP);
   endfunction

   // Register read view
   function automatic logic [31:0] read_view(
         input brownout_reset_pkg::state_type s,
         input logic [1:0]                    idx,
         input logic                          ready);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (idx)
         brownout_reset_pkg::IDX_CTRL_STATUS:
         begin
            d[brownout_reset_pkg::CSR_SW_EN_BIT] = s.sw_en;
            d[brownout_reset_pkg::CSR_READY_BIT] = ready;
         end
         brownout_reset_pkg::IDX_CONFIG:
         begin
            d[brownout_reset_pkg::CFG_MODE_LSB +: 2] = s.mode;
            d[brownout_reset_pkg::CFG_PUD_N_BIT]     = s.pud_n;
         end
         brownout_reset_pkg::IDX_INT_STATUS:
            d[brownout_reset_pkg::INT_W-1:0] = s.int_status;
         brownout_reset_pkg::IDX_INT_MASK:
            d[brownout_reset_pkg::INT_W-1:0] = s.int_mask;
      endcase
      return d;
   endfunction

   assign por_low    = st_reg.sync2[brownout_reset_pkg::SY_POR];
   assign below      = st_reg.sync2[brownout_reset_pkg::SY_LOW];
   assign pin_low    = !st_reg.sync2[brownout_reset_pkg::SY_PIN];
   assign bor_active = detector_on(st_reg.mode, st_reg.sw_en, i_sleep);
   // Protection only once the detector is ready, sleep aside
   assign rdy        = bor_active &&
                       st_reg.sync2[brownout_reset_pkg::SY_RDY];
   assign bor_cond   = rdy && below;
   assign bor_event  = bor_cond && (st_reg.phase != brownout_reset_pkg::PH_HOLD)
                       && (st_reg.dg_cnt == DG_LAST);
   assign pud_done   = (st_reg.phase == brownout_reset_pkg::PH_DELAY) &&
                       (st_reg.pud_cnt == PUD_LAST);
   assign take       = i_hsel && i_htrans[1] && i_hready;
   assign mapped     = (i_haddr[31:4] == 28'h000_0000);

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb
   begin
      st_next       = st_reg;
      int_clr       = '0;
      int_set       = '0;
      // Pins and analog levels cross into the clock domain here
      st_next.sync1 = {i_ext_reset_n, i_bor_circuit_rdy, i_below_threshold,
                       i_por_low};
      st_next.sync2 = st_reg.sync1;

      // Deglitch: dips shorter than the filter never trip
      if (!bor_cond || st_reg.phase == brownout_reset_pkg::PH_HOLD)
         st_next.dg_cnt = '0;
      else if (!bor_event)
         st_next.dg_cnt = st_reg.dg_cnt + 1'b1;

      unique case (st_reg.phase)
         brownout_reset_pkg::PH_HOLD:
            if (!por_low && !bor_cond)
               st_next.phase = brownout_reset_pkg::PH_WAIT_BOR;
         brownout_reset_pkg::PH_WAIT_BOR:
            if (!waits_for_detector(st_reg.mode) ||
                (rdy && !below))
            begin
               st_next.pud_cnt  = '0;
               st_next.phase    = st_reg.pud_n ?
                                  brownout_reset_pkg::PH_RUN :
                                  brownout_reset_pkg::PH_DELAY;
            end
         brownout_reset_pkg::PH_DELAY:
            if (pud_done)
               st_next.phase = brownout_reset_pkg::PH_RUN;
            else
               st_next.pud_cnt = st_reg.pud_cnt + 1'b1;
         brownout_reset_pkg::PH_RUN:
            st_next.phase = brownout_reset_pkg::PH_RUN;
      endcase

      // Supply events and programming mode exit restart the whole sequence
      if (por_low || bor_event || i_prog_exit)
      begin
         st_next.phase = brownout_reset_pkg::PH_HOLD;
         st_next.sw_en = brownout_reset_pkg::SW_EN_RESET;
      end

      st_next.pulse_rst = i_wdt_reset || i_reset_instr ||
                          i_stack_overflow || i_stack_underflow;
      // Pin reset does not stop the delay; it only gates the output
      st_next.rstn = (st_next.phase == brownout_reset_pkg::PH_RUN) &&
                     !pin_low && !st_next.pulse_rst;

      // Bus: address phase
      if (take)
      begin
         st_next.dp_wr  = i_hwrite;
         st_next.dp_ok  = mapped;
         st_next.dp_idx = i_haddr[3:2];
         if (!i_hwrite)
         begin
            st_next.hrdata = mapped ?
                             read_view(st_reg, i_haddr[3:2], rdy) :
                             32'h0000_0000;
            if (mapped && i_haddr[3:2] == brownout_reset_pkg::IDX_INT_STATUS)
               int_clr = st_reg.int_status;
         end
      end
      else
         st_next.dp_wr = 1'b0;

      // Bus: data phase of a write
      if (st_reg.dp_wr && st_reg.dp_ok)
      begin
         unique case (st_reg.dp_idx)
            brownout_reset_pkg::IDX_CTRL_STATUS:
               if (!(por_low || bor_event || i_prog_exit))
                  st_next.sw_en =
                     i_hwdata[brownout_reset_pkg::CSR_SW_EN_BIT];
            brownout_reset_pkg::IDX_CONFIG:
            begin
               st_next.mode =
                  i_hwdata[brownout_reset_pkg::CFG_MODE_LSB +: 2];
               st_next.pud_n =
                  i_hwdata[brownout_reset_pkg::CFG_PUD_N_BIT];
            end
            brownout_reset_pkg::IDX_INT_STATUS:
               st_next.int_status = st_reg.int_status;
            brownout_reset_pkg::IDX_INT_MASK:
               st_next.int_mask = i_hwdata[brownout_reset_pkg::INT_W-1:0];
         endcase
      end

      // Events: a set in the same cycle as a read-clear wins
      int_set[brownout_reset_pkg::INT_BOR_BIT]   = bor_event;
      int_set[brownout_reset_pkg::INT_PUD_BIT]   = pud_done;
      int_set[brownout_reset_pkg::INT_READY_BIT] = rdy && !st_reg.rdy_prev;
      st_next.int_status = (st_reg.int_status & ~int_clr) | int_set;
      st_next.rdy_prev   = rdy;
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st_reg            <= '0;
         st_reg.phase      <= brownout_reset_pkg::PH_HOLD;
         st_reg.sw_en      <= brownout_reset_pkg::SW_EN_RESET;
         st_reg.mode       <= brownout_reset_pkg::MODE_RESET;
         st_reg.pud_n      <= brownout_reset_pkg::PUD_N_RESET;
         st_reg.int_mask   <= brownout_reset_pkg::INT_MASK_RESET;
         st_reg.rstn       <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign o_hrdata          = st_reg.hrdata;
   assign o_hreadyout       = 1'b1;
   assign o_hresp           = 1'b0;
   assign o_device_reset_n  = st_reg.rstn;
   assign o_brownout_enable = bor_active;
   // Mode 10 holds wake-up until the detector is back
   assign o_wake_ready      =
      (st_reg.mode != brownout_reset_pkg::MODE_OFF_IN_SLEEP) ||
      st_reg.sync2[brownout_reset_pkg::SY_RDY];
   assign o_irq             = |(st_reg.int_status & st_reg.int_mask);

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   sequence read_csr_s;
      take && !i_hwrite && mapped &&
      i_haddr[3:2] == brownout_reset_pkg::IDX_CTRL_STATUS;
   endsequence

   sequence csr_zero_s;
      o_hrdata[6:1] == 6'h00 &&
      o_hrdata[brownout_reset_pkg::CSR_SW_EN_BIT] == $past(st_reg.sw_en);
   endsequence

   sequence delay_end_s;
      st_reg.phase == brownout_reset_pkg::PH_RUN &&
      $past(st_reg.phase) == brownout_reset_pkg::PH_DELAY;
   endsequence

   reset_during_delay_a: assert property (
      st_reg.phase != brownout_reset_pkg::PH_RUN |-> !o_device_reset_n)
      else $error("device reset released before run phase");

   por_holds_a: assert property (
      por_low |=> st_reg.phase == brownout_reset_pkg::PH_HOLD ##1
      !o_device_reset_n)
      else $error("power-on low did not hold reset");

   delay_length_a: assert property (
      delay_end_s |-> $past(st_reg.pud_cnt) == PUD_LAST)
      else $error("power-up delay ended at wrong count");

   delay_bypass_a: assert property (
      $rose(st_reg.phase == brownout_reset_pkg::PH_DELAY) |->
      !$past(st_reg.pud_n))
      else $error("delay ran while bypassed");

   delay_start_a: assert property (
      st_reg.phase == brownout_reset_pkg::PH_HOLD && (por_low || bor_cond)
      |=> st_reg.phase == brownout_reset_pkg::PH_HOLD)
      else $error("sequence left hold with a supply condition present");

   mode_enable_a: assert property (
      (st_reg.mode == brownout_reset_pkg::MODE_ALWAYS_OFF |->
       !o_brownout_enable) and
      (st_reg.mode == brownout_reset_pkg::MODE_ALWAYS_ON |->
       o_brownout_enable))
      else $error("detector enable does not follow mode");

   deglitch_count_a: assert property (
      bor_event |-> $past(bor_cond, 1) && st_reg.dg_cnt == DG_LAST)
      else $error("brown-out reset before deglitch time");

   startup_wait_a: assert property (
      st_reg.phase == brownout_reset_pkg::PH_WAIT_BOR &&
      waits_for_detector(st_reg.mode) && !(rdy && !below) &&
      !por_low && !i_prog_exit
      |=> st_reg.phase == brownout_reset_pkg::PH_WAIT_BOR)
      else $error("start-up did not wait for the detector");

   wake_hold_a: assert property (
      st_reg.mode == brownout_reset_pkg::MODE_OFF_IN_SLEEP &&
      !st_reg.sync2[brownout_reset_pkg::SY_RDY] |-> !o_wake_ready)
      else $error("wake-up allowed before detector ready");

   sw_enable_set_a: assert property (
      bor_event |=> st_reg.sw_en && !o_device_reset_n)
      else $error("software enable not set by brown-out");

   csr_read_a: assert property (
      read_csr_s |=> csr_zero_s)
      else $error("control/status read shows wrong bits");

   sw_mode_off_a: assert property (
      st_reg.mode == brownout_reset_pkg::MODE_SW_CTRL && !st_reg.sw_en
      |-> !o_brownout_enable)
      else $error("detector on with software enable clear");

endmodule // brownout_powerup_reset_ctrl

`default_nettype wire

//--- brownout_detector_model.sv
// Behavioural model of the analog power-on and brown-out detectors
`timescale 1ns/1ns
`default_nettype none

module brownout_detector_model #(
   parameter int unsigned RDY_DLY = 4
) (
   input  wire logic i_ref_clk,    // Device clock
   input  wire logic i_enable,     // Detector enable from the block
   input  wire logic i_supply_low, // Bench: supply under brown-out level
   input  wire logic i_power_low,  // Bench: supply under power-on level
   output logic      o_por_low,    // Power-on detector output
   output logic      o_below,      // Brown-out comparator output
   output logic      o_ready       // Detector settled and active
);
   int unsigned cnt  = 0;
   logic        junk = 1'b0;

   // Settling restarts whenever the detector is switched off
   always @(posedge i_ref_clk)
   begin
      cnt  <= i_enable ? ((cnt < RDY_DLY) ? cnt + 1 : cnt) : 0;
      junk <= !junk;
   end

   assign o_ready   = i_enable && (cnt == RDY_DLY);
   // An unpowered comparator says nothing useful, so it churns
   assign o_below   = i_enable ? i_supply_low : junk;
   assign o_por_low = i_power_low;
endmodule // brownout_detector_model

`default_nettype wire

//--- brownout_powerup_reset_ctrl_test.sv
// Self-checking bench for the reset sequencing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end

module brownout_powerup_reset_ctrl_test;
   localparam int DLY = 20;
   logic        clk     = 1'b0;
   logic        rstn    = 1'b0;
   logic        sup_low = 1'b0;
   logic        pwr_low = 1'b0;
   logic        pin_n   = 1'b1;
   logic        slp     = 1'b0;
   logic [4:0]  pul     = 5'h00;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hready, hresp, dev_rst_n, bor_en, wake, irq, por, below, rdy;
   int          errors    = 0;
   int          cmp_count = 0;
   int          k;

   always #50 clk = ~clk;

   brownout_powerup_reset_ctrl #(.POWERUP_DELAY_CYCLES(DLY),
      .DEGLITCH_CYCLES(3)) DUT (
      .i_ref_clk(clk), .i_resetn(rstn), .i_por_low(por),
      .i_below_threshold(below), .i_bor_circuit_rdy(rdy),
      .i_ext_reset_n(pin_n), .i_wdt_reset(pul[0]),
      .i_reset_instr(pul[1]), .i_stack_overflow(pul[2]),
      .i_stack_underflow(pul[3]), .i_prog_exit(pul[4]), .i_sleep(slp),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
      .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .o_device_reset_n(dev_rst_n),
      .o_brownout_enable(bor_en), .o_wake_ready(wake), .o_irq(irq));

   brownout_detector_model MODEL (.i_ref_clk(clk), .i_enable(bor_en),
      .i_supply_low(sup_low), .i_power_low(pwr_low), .o_por_low(por),
      .o_below(below), .o_ready(rdy));

   // ------------------------------------------------------------------
   // Bus and timing helpers
   // ------------------------------------------------------------------
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // Counts falling edges until the merged reset shows v, at most n
   task automatic wait_rst(input logic v, input int n);
      k = 0;
      while (dev_rst_n !== v && k < n)
      begin
         @(negedge clk);
         k++;
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      bus(0, 32'h0, 32'h0);
      `CHK("csr", 32'h81, rd)
      `CHK("resp", 1'b0, hresp)
      bus(0, 32'h4, 32'h0);
      `CHK("cfg", 32'h3, rd)
      bus(0, 32'h10, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1, 32'h0, 32'h7E);
      bus(0, 32'h0, 32'h0);
      `CHK("csr wr", 32'h01, rd)
      bus(1, 32'h0, 32'h80);
      $display("test regs done");
   endtask

   task automatic t_pulses();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         pul <= 5'h01 << i;
         @(posedge clk);
         pul <= 5'h00;
         @(negedge clk);
         `CHK("pulse low", 1'b0, dev_rst_n)
         @(negedge clk);
         `CHK("pulse high", 1'b1, dev_rst_n)
      end
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK("pin", 1'b0, dev_rst_n)
      @(posedge clk);
      pin_n <= 1'b1;
      wait_rst(1'b1, 8);
      `CHK("pin release", 1'b1, k < 8)
      $display("test pulses done");
   endtask

   task automatic t_modes();
      bus(1, 32'h4, 32'h1);
      bus(1, 32'h0, 32'h0);
      repeat (4) @(negedge clk);
      `CHK("sw off", 1'b0, bor_en)
      bus(0, 32'h0, 32'h0);
      `CHK("csr off", 32'h0, rd)
      bus(1, 32'h0, 32'h80);
      @(negedge clk);
      `CHK("sw on", 1'b1, bor_en)
      `CHK("sw wake", 1'b1, wake)
      @(posedge clk);
      slp <= 1'b1;
      @(negedge clk);
      `CHK("sw sleep", 1'b1, bor_en)
      @(posedge clk);
      slp <= 1'b0;
      bus(1, 32'h4, 32'h0);
      @(negedge clk);
      `CHK("off", 1'b0, bor_en)
      bus(1, 32'h4, 32'h2);
      slp <= 1'b1;
      repeat (8) @(negedge clk);
      `CHK("nsleep en", 1'b0, bor_en)
      `CHK("nsleep wake", 1'b0, wake)
      @(posedge clk);
      slp <= 1'b0;
      repeat (10) @(negedge clk);
      `CHK("nsleep woke", 1'b1, wake)
      bus(1, 32'h4, 32'h3);
      slp <= 1'b1;
      repeat (8) @(negedge clk);
      `CHK("on en", 1'b1, bor_en)
      `CHK("on wake", 1'b1, wake)
      @(posedge clk);
      slp <= 1'b0;
      $display("test modes done");
   endtask

   task automatic t_brown();
      bus(1, 32'hC, 32'h1);
      bus(1, 32'h0, 32'h0);
      @(negedge clk);
      `CHK("sw ignored", 1'b1, bor_en)
      @(posedge clk);
      sup_low <= 1'b1;
      repeat (2) @(posedge clk);
      sup_low <= 1'b0;
      wait_rst(1'b0, 10);
      `CHK("glitch", 10, k)
      @(posedge clk);
      sup_low <= 1'b1;
      wait_rst(1'b0, 12);
      `CHK("trip", 1'b1, k < 12)
      repeat (5) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      sup_low <= 1'b0;
      wait_rst(1'b1, 60);
      `CHK("bor delay", 1'b1, k >= DLY)
      bus(0, 32'h0, 32'h0);
      `CHK("csr forced", 32'h81, rd)
      bus(0, 32'h8, 32'h0);
      `CHK("int bor", 1'b1, rd[0])
      @(negedge clk);
      `CHK("irq clr", 1'b0, irq)
      $display("test brown done");
   endtask

   task automatic t_por();
      @(posedge clk);
      pwr_low <= 1'b1;
      repeat (30) @(negedge clk);
      `CHK("por hold", 1'b0, dev_rst_n)
      @(posedge clk);
      pwr_low <= 1'b0;
      wait_rst(1'b1, 60);
      `CHK("por delay", 1'b1, k >= DLY)
      bus(1, 32'h4, 32'h7);
      pul <= 5'h10;
      @(posedge clk);
      pul <= 5'h00;
      wait_rst(1'b0, 6);
      `CHK("prog exit", 1'b0, dev_rst_n)
      wait_rst(1'b1, 12);
      `CHK("bypass", 1'b1, k < 12)
      $display("test por done");
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      wait_rst(1'b1, 60);
      `CHK("startup", 1'b1, (k >= DLY) && (k < 40))
      t_regs();
      t_pulses();
      t_modes();
      t_brown();
      t_por();
      report_and_stop();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      #(5000 * 100);
      errors++;
      report_and_stop();
   end
endmodule // brownout_powerup_reset_ctrl_test

`default_nettype wire
